// ===== char_disp_pkg.sv
// Purpose: Shared constants, types and decode for the character display instruction decoder.
// Assumes: 125 MHz system clock; internal oscillator nominally 250 kHz, made by division.
// Notes: Register offsets are Wishbone byte addresses of 32-bit words.
package char_disp_pkg;

	// ==========================================================
	// Register map
	localparam logic [3:0] ADR_INSTR = 4'h0;
	localparam logic [3:0] ADR_DATA = 4'h4;
	localparam logic [3:0] ADR_STATUS = 4'h8;
	localparam int STAT_REJECT_BIT = 16;

	// ==========================================================
	// Instruction field positions
	localparam int ENTRY_INC_BIT = 1;
	localparam int ENTRY_SHIFT_BIT = 0;
	localparam int DISP_ON_BIT = 2;
	localparam int CURSOR_BIT = 1;
	localparam int BLINK_BIT = 0;
	localparam int SC_BIT = 3;
	localparam int RL_BIT = 2;
	localparam int GC_BIT = 3;
	localparam int PWR_BIT = 2;
	localparam int WIDTH_BIT = 4;
	localparam int LINES_BIT = 3;
	localparam int FONT_BIT = 2;

	// ==========================================================
	// Sizes and reset values
	localparam int ADDR_W = 7;
	localparam int DISP_DEPTH = 128;
	localparam int GLYPH_DEPTH = 64;
	localparam logic [7:0] BLANK_CODE = 8'h20;
	localparam logic [1:0] FT_RST = 2'h0;
	localparam logic [1:0] FT_NONE = 2'h3;
	localparam logic BW_RST = 1'b1;
	localparam logic INC_RST = 1'b1;

	// ==========================================================
	// Timing
	localparam int CLK_HZ = 125_000_000;
	localparam int OSC_HZ = 250_000;
	localparam int CLEAR_TIME_US = 6200;
	localparam int OSC_DIV_CYC = CLK_HZ / OSC_HZ;
	// Longest time rounds down to whole oscillator ticks
	localparam int CLEAR_OSC_TICKS = CLEAR_TIME_US * (OSC_HZ / 1000) / 1000;
	localparam int OTHER_OSC_TICKS = 1;

	// ==========================================================
	// Types
	typedef enum logic [3:0] {
		CMD_NONE = 4'h0,
		CMD_CLEAR = 4'h1,
		CMD_HOME = 4'h2,
		CMD_ENTRY = 4'h3,
		CMD_DISPLAY = 4'h4,
		CMD_SHIFT = 4'h5,
		CMD_MODE_PWR = 4'h6,
		CMD_FUNC = 4'h7,
		CMD_GLYPH_ADDR = 4'h8,
		CMD_DISP_ADDR = 4'h9
	} cmd_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_FILL = 2'b01,
		ST_BUSY = 2'b10
	} state_e;

	typedef struct packed {
		logic top_zero;
		logic [6:0] shift;
		logic [6:0] mid_zero;
		logic rejected;
		logic [1:0] font_table;
		logic font;
		logic lines;
		logic bus_width_select;
		logic dcdc_on;
		logic graphic;
		logic blink;
		logic cursor;
		logic display_on;
		logic shift_en;
		logic inc;
		logic glyph_sel;
		logic [2:0] low_zero;
	} status_s;

	// Highest set bit picks the instruction class
	function automatic cmd_e decode_cmd(input logic [7:0] b);
		cmd_e c;
		c = CMD_NONE;
		if (b[7]) begin
			c = CMD_DISP_ADDR;
		end else if (b[6]) begin
			c = CMD_GLYPH_ADDR;
		end else if (b[5]) begin
			c = CMD_FUNC;
		end else if (b[4]) begin
			if (b[1:0] == 2'h0) c = CMD_SHIFT;
			else if (b[1:0] == 2'h3) c = CMD_MODE_PWR;
		end else if (b[3]) begin
			c = CMD_DISPLAY;
		end else if (b[2]) begin
			c = CMD_ENTRY;
		end else if (b[1]) begin
			c = CMD_HOME;
		end else if (b[0]) begin
			c = CMD_CLEAR;
		end
		return c;
	endfunction

endpackage

// ===== char_display_instruction_decoder.sv
// The placing of the registers and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
// Purpose: Instruction decoder of a character display controller, Wishbone slave.
// Assumes: Wishbone classic master on clk_i; one access outstanding.
// Notes: Word 0 is the instruction register, word 1 the data register, word 2 status.
module char_display_instruction_decoder #(
	parameter int unsigned OSC_DIV = char_disp_pkg::OSC_DIV_CYC,
	parameter int unsigned CLEAR_TICKS = char_disp_pkg::CLEAR_OSC_TICKS,
	parameter int unsigned OTHER_TICKS = char_disp_pkg::OTHER_OSC_TICKS
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	output logic busy_flag_o,
	output logic display_on_o,
	output logic graphic_mode_o,
	output logic dcdc_on_o
);
	localparam int DIV_W = $clog2(OSC_DIV + 1);
	localparam int TICK_W = $clog2(CLEAR_TICKS + OTHER_TICKS + 1);
	localparam int AW = char_disp_pkg::ADDR_W;

	// ==========================================================
	// Declarations
	logic ack_q;
	logic [31:0] dat_q;
	logic nib_q;
	logic [3:0] nib_hi_q;
	logic [7:0] instruction_register_q;
	logic [7:0] data_holding_register_q;
	logic pend_q;
	logic pend_data_q;
	logic pend_rd_q;
	logic rejected_q;
	char_disp_pkg::state_e state_q;
	logic [DIV_W-1:0] osc_cnt_q;
	logic [TICK_W-1:0] tick_cnt_q;
	logic [AW-1:0] fill_cnt_q;
	logic step_q;
	logic [AW-1:0] address_counter_q;
	logic glyph_sel_q;
	logic [6:0] shift_q;
	logic inc_q;
	logic shift_en_q;
	logic disp_on_q;
	logic cursor_q;
	logic blink_q;
	logic gc_q;
	logic pwr_q;
	logic bus_width_select_q;
	logic lines_q;
	logic font_q;
	logic [1:0] font_table_q;

	logic req;
	logic acc;
	logic is_instr;
	logic is_data;
	logic is_status;
	logic byte_acc;
	logic byte_done;
	logic busy_flag;
	logic exec;
	logic tick;
	logic busy_done;
	logic filling;
	logic fill_last;
	logic [7:0] byte_in;
	logic [7:0] rd_byte;
	logic [7:0] rd_lane;
	char_disp_pkg::cmd_e cmd;
	char_disp_pkg::status_s status;

	ram_port_if ram_if ();

	char_ram u_ram (
		.clk_i(clk_i),
		.port(ram_if)
	);

	// Glyph addresses wrap within six bits, display addresses within seven
	function automatic logic [AW-1:0] next_addr(input logic [AW-1:0] a, input logic up,
			input logic glyph);
		logic [AW-1:0] n;
		n = up ? a + 1'b1 : a - 1'b1;
		if (glyph) n[AW-1] = 1'b0;
		return n;
	endfunction

	// ==========================================================
	// Decode of the bus access
	assign req = cyc_i & stb_i & ~ack_q;
	assign acc = cyc_i & stb_i & ack_q;
	assign is_instr = adr_i[3:2] == char_disp_pkg::ADR_INSTR[3:2];
	assign is_data = adr_i[3:2] == char_disp_pkg::ADR_DATA[3:2];
	assign is_status = adr_i[3:2] == char_disp_pkg::ADR_STATUS[3:2];
	assign byte_acc = acc & (is_instr | is_data) & (~we_i | sel_i[0]);
	assign byte_done = byte_acc & (bus_width_select_q | nib_q);
	assign byte_in = bus_width_select_q ? dat_i[7:0] : {nib_hi_q, dat_i[7:4]};
	assign busy_flag = (state_q != char_disp_pkg::ST_IDLE) | pend_q;
	assign exec = pend_q;
	assign cmd = pend_data_q ? char_disp_pkg::CMD_NONE
		: char_disp_pkg::decode_cmd(instruction_register_q);
	assign tick = osc_cnt_q == DIV_W'(OSC_DIV - 1);
	assign filling = state_q == char_disp_pkg::ST_FILL;
	assign fill_last = filling && fill_cnt_q == AW'(char_disp_pkg::DISP_DEPTH - 1);
	assign busy_done = state_q == char_disp_pkg::ST_BUSY && tick && tick_cnt_q <= TICK_W'(1);
	assign rd_byte = is_instr ? {busy_flag, address_counter_q} : ram_if.rdata;
	assign rd_lane = bus_width_select_q ? rd_byte
		: (nib_q ? {rd_byte[3:0], 4'h0} : {rd_byte[7:4], 4'h0});

	always_comb begin
		status = '0;
		status.shift = shift_q;
		status.rejected = rejected_q;
		status.font_table = font_table_q;
		status.font = font_q;
		status.lines = lines_q;
		status.bus_width_select = bus_width_select_q;
		status.dcdc_on = pwr_q;
		status.graphic = gc_q;
		status.blink = blink_q;
		status.cursor = cursor_q;
		status.display_on = disp_on_q;
		status.shift_en = shift_en_q;
		status.inc = inc_q;
		status.glyph_sel = glyph_sel_q;
	end

	// ==========================================================
	// Wishbone answer: ack one cycle after the strobe, data registered
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= '0;
		end else begin
			ack_q <= req;
			if (req && !we_i) begin
				if (is_status) dat_q <= status;
				else if (is_instr || is_data) dat_q <= {24'h0, rd_lane};
				else dat_q <= '0;
			end
		end
	end

	// ==========================================================
	// Host latch: bytes are held before any internal operation starts
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			nib_q <= 1'b0;
			nib_hi_q <= 4'h0;
			instruction_register_q <= 8'h00;
			data_holding_register_q <= 8'h00;
			pend_q <= 1'b0;
			pend_data_q <= 1'b0;
			pend_rd_q <= 1'b0;
			rejected_q <= 1'b0;
		end else begin
			if (byte_acc && !bus_width_select_q) nib_q <= ~nib_q;
			if (byte_acc && we_i && !bus_width_select_q && !nib_q) nib_hi_q <= dat_i[7:4];
			pend_q <= 1'b0;
			if (byte_done && !busy_flag && (we_i || is_data)) begin
				pend_q <= 1'b1;
				pend_data_q <= is_data;
				pend_rd_q <= ~we_i;
				if (we_i && is_instr) instruction_register_q <= byte_in;
				if (we_i && is_data) data_holding_register_q <= byte_in;
			end
			// A refused access is noted; a new refusal wins over the clear
			if (byte_done && busy_flag && (we_i || is_data)) begin
				rejected_q <= 1'b1;
			end else if (acc && we_i && is_status && sel_i[2] && dat_i[char_disp_pkg::STAT_REJECT_BIT]) begin
				rejected_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Busy timing from the divided oscillator
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= char_disp_pkg::ST_IDLE;
			osc_cnt_q <= '0;
			tick_cnt_q <= '0;
			fill_cnt_q <= '0;
			step_q <= 1'b0;
		end else begin
			osc_cnt_q <= tick ? '0 : osc_cnt_q + 1'b1;
			if (tick && tick_cnt_q != '0) tick_cnt_q <= tick_cnt_q - 1'b1;
			case (state_q)
				char_disp_pkg::ST_IDLE: begin
					if (exec) begin
						if (cmd == char_disp_pkg::CMD_CLEAR) begin
							state_q <= char_disp_pkg::ST_FILL;
							tick_cnt_q <= TICK_W'(CLEAR_TICKS);
						end else begin
							state_q <= char_disp_pkg::ST_BUSY;
							tick_cnt_q <= TICK_W'(OTHER_TICKS);
						end
						fill_cnt_q <= '0;
						step_q <= pend_data_q;
					end
				end
				char_disp_pkg::ST_FILL: begin
					fill_cnt_q <= fill_cnt_q + 1'b1;
					if (fill_last) state_q <= char_disp_pkg::ST_BUSY;
				end
				char_disp_pkg::ST_BUSY: begin
					if (busy_done) begin
						state_q <= char_disp_pkg::ST_IDLE;
						step_q <= 1'b0;
					end
				end
				default: state_q <= char_disp_pkg::ST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Shared address counter, also the cursor position
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			address_counter_q <= '0;
			glyph_sel_q <= 1'b0;
		end else if (exec) begin
			case (cmd)
				char_disp_pkg::CMD_CLEAR, char_disp_pkg::CMD_HOME: begin
					address_counter_q <= '0;
					glyph_sel_q <= 1'b0;
				end
				char_disp_pkg::CMD_SHIFT: begin
					if (!instruction_register_q[char_disp_pkg::SC_BIT]) begin
						address_counter_q <= next_addr(address_counter_q,
							instruction_register_q[char_disp_pkg::RL_BIT], glyph_sel_q);
					end
				end
				char_disp_pkg::CMD_GLYPH_ADDR: begin
					address_counter_q <= {1'b0, instruction_register_q[5:0]};
					glyph_sel_q <= 1'b1;
				end
				char_disp_pkg::CMD_DISP_ADDR: begin
					address_counter_q <= instruction_register_q[6:0];
					glyph_sel_q <= 1'b0;
				end
				default: begin
				end
			endcase
		end else if (busy_done && step_q) begin
			// The step becomes visible only as busy drops
			address_counter_q <= next_addr(address_counter_q, inc_q, glyph_sel_q);
		end
	end

	// ==========================================================
	// Mode and display settings
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			shift_q <= '0;
			inc_q <= char_disp_pkg::INC_RST;
			shift_en_q <= 1'b0;
			disp_on_q <= 1'b0;
			cursor_q <= 1'b0;
			blink_q <= 1'b0;
			gc_q <= 1'b0;
			pwr_q <= 1'b0;
			bus_width_select_q <= char_disp_pkg::BW_RST;
			lines_q <= 1'b0;
			font_q <= 1'b0;
			font_table_q <= char_disp_pkg::FT_RST;
		end else if (exec) begin
			if (pend_data_q && shift_en_q) begin
				// Increment direction moves the picture left
				shift_q <= inc_q ? shift_q + 1'b1 : shift_q - 1'b1;
			end
			case (cmd)
				char_disp_pkg::CMD_CLEAR: begin
					shift_q <= '0;
					inc_q <= 1'b1;
				end
				char_disp_pkg::CMD_HOME: shift_q <= '0;
				char_disp_pkg::CMD_ENTRY: begin
					inc_q <= instruction_register_q[char_disp_pkg::ENTRY_INC_BIT];
					shift_en_q <= instruction_register_q[char_disp_pkg::ENTRY_SHIFT_BIT];
				end
				char_disp_pkg::CMD_DISPLAY: begin
					disp_on_q <= instruction_register_q[char_disp_pkg::DISP_ON_BIT];
					cursor_q <= instruction_register_q[char_disp_pkg::CURSOR_BIT];
					blink_q <= instruction_register_q[char_disp_pkg::BLINK_BIT];
				end
				char_disp_pkg::CMD_SHIFT: begin
					if (instruction_register_q[char_disp_pkg::SC_BIT]) begin
						shift_q <= instruction_register_q[char_disp_pkg::RL_BIT]
							? shift_q - 1'b1 : shift_q + 1'b1;
					end
				end
				char_disp_pkg::CMD_MODE_PWR: begin
					gc_q <= instruction_register_q[char_disp_pkg::GC_BIT];
					pwr_q <= instruction_register_q[char_disp_pkg::PWR_BIT];
				end
				char_disp_pkg::CMD_FUNC: begin
					bus_width_select_q <= instruction_register_q[char_disp_pkg::WIDTH_BIT];
					lines_q <= instruction_register_q[char_disp_pkg::LINES_BIT];
					font_q <= instruction_register_q[char_disp_pkg::FONT_BIT];
					if (instruction_register_q[1:0] != char_disp_pkg::FT_NONE) begin
						font_table_q <= instruction_register_q[1:0];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// ==========================================================
	// RAM port: clear fill has the port, else the address counter
	always_comb begin
		ram_if.we = filling | (exec & pend_data_q & ~pend_rd_q);
		ram_if.glyph = filling ? 1'b0 : glyph_sel_q;
		ram_if.addr = filling ? fill_cnt_q : address_counter_q;
		ram_if.wdata = filling ? char_disp_pkg::BLANK_CODE : data_holding_register_q;
	end

	assign dat_o = dat_q;
	assign ack_o = ack_q;
	assign busy_flag_o = busy_flag;
	assign display_on_o = disp_on_q;
	assign graphic_mode_o = gc_q;
	assign dcdc_on_o = pwr_q;

	// ==========================================================
	// Assertions
	logic [31:0] busy_len_q;

	always_ff @(posedge clk_i) begin
		if (rst_i || !busy_flag) busy_len_q <= '0;
		else busy_len_q <= busy_len_q + 1'b1;
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_latch;
		byte_done && we_i && is_instr && !busy_flag |=> pend_q && instruction_register_q == $past(byte_in);
	endproperty
	a_latch: assert property (p_latch) else $error("instruction byte not latched");

	property p_reject;
		byte_done && busy_flag && we_i |=> !pend_q && rejected_q;
	endproperty
	a_reject: assert property (p_reject) else $error("access accepted while busy");

	property p_busy_read;
		req && !we_i && is_instr && bus_width_select_q |=> dat_o[7] == $past(busy_flag);
	endproperty
	a_busy_read: assert property (p_busy_read) else $error("busy bit wrong on read");

	property p_clear;
		exec && cmd == char_disp_pkg::CMD_CLEAR
			|=> address_counter_q == '0 && shift_q == '0 && inc_q && $stable(shift_en_q) && filling;
	endproperty
	a_clear: assert property (p_clear) else $error("clear did not reset state");

	property p_home;
		exec && cmd == char_disp_pkg::CMD_HOME |=> address_counter_q == '0 && shift_q == '0 && !filling;
	endproperty
	a_home: assert property (p_home) else $error("return home wrong");

	property p_glyph_addr;
		exec && cmd == char_disp_pkg::CMD_GLYPH_ADDR
			|=> glyph_sel_q && address_counter_q == {1'b0, $past(instruction_register_q[5:0])};
	endproperty
	a_glyph_addr: assert property (p_glyph_addr) else $error("glyph address wrong");

	property p_disp_addr;
		exec && cmd == char_disp_pkg::CMD_DISP_ADDR
			|=> !glyph_sel_q && address_counter_q == $past(instruction_register_q[6:0]);
	endproperty
	a_disp_addr: assert property (p_disp_addr) else $error("display address wrong");

	property p_addr_hold;
		state_q != char_disp_pkg::ST_IDLE && !busy_done |=> $stable(address_counter_q);
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("address moved while busy");

	property p_mode_pwr;
		exec && cmd == char_disp_pkg::CMD_MODE_PWR
			|=> gc_q == $past(instruction_register_q[3]) && pwr_q == $past(instruction_register_q[2]);
	endproperty
	a_mode_pwr: assert property (p_mode_pwr) else $error("mode or power bit wrong");

	property p_font_table;
		font_table_q != char_disp_pkg::FT_NONE;
	endproperty
	a_font_table: assert property (p_font_table) else $error("font table holds 11");

	property p_busy_len;
		busy_len_q <= (CLEAR_TICKS + 1) * OSC_DIV + 1;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy period too long");

	c_clear_done: cover property (filling ##1 !filling [*1] ##[1:1000] !busy_flag);
	c_data_write: cover property (exec && pend_data_q && !pend_rd_q);
	c_nibble: cover property (byte_done && !bus_width_select_q);
	c_refused: cover property (byte_done && busy_flag);
endmodule

// ===== char_display_instruction_decoder_tb.sv
// Purpose: Self-checking bench for the character display instruction decoder.
// Assumes: Shortened busy timing: four cycles a tick, forty ticks for clear.
// Notes: Every wait polls the busy flag under a bound.
`timescale 1ns/1ps
module char_display_instruction_decoder_tb;
	logic clk_i;
	logic rst_i;
	logic cyc, stb, we, ack, busy, don, gm, dc, hang;
	logic [3:0] adr, sel;
	logic [31:0] wdat, rdat, v, v2;
	logic four_bit;
	int mismatches;
	int samples_checked;
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	char_display_instruction_decoder #(.OSC_DIV(4), .CLEAR_TICKS(40), .OTHER_TICKS(1))
		i_char_display_instruction_decoder (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat),
		.ack_o(ack), .busy_flag_o(busy), .display_on_o(don), .graphic_mode_o(gm),
		.dcdc_on_o(dc));
	host_model i_host_model (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc),
		.stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat), .hang_o(hang));
	// ==========================================================
	// Checking
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// In narrow mode every poll is a pair of reads, so the nibble phase stays aligned
	task automatic idle();
		int n;
		logic [31:0] lo;
		n = 0;
		do begin
			i_host_model.rd(4'h0, v);
			if (four_bit) begin
				i_host_model.rd(4'h0, lo);
				v = {24'h0, v[7:4], lo[7:4]};
			end
			n++;
		end while (v[7] !== 1'b0 && n < 400);
		if (v[7] !== 1'b0) begin
			mismatches++;
			$display("mismatch busy_wait expected 0 seen 1");
			report_and_stop();
		end
	endtask
	always @(posedge hang) begin
		mismatches++;
		$display("mismatch bus_ack expected 1 seen 0");
		report_and_stop();
	end
	// ==========================================================
	// Tests
	initial begin
		rst_i = 1'b1;
		mismatches = 0;
		samples_checked = 0;
		four_bit = 1'b0;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		i_host_model.rd(4'h8, v);
		chk("reset_status", 32'h0000_0810, v & 32'h0000_f838);
		i_host_model.wr(4'h0, 32'h85);
		idle();
		chk("addr_set", 32'h05, v & 32'hff);
		i_host_model.wr(4'h4, 32'h41);
		idle();
		chk("addr_step", 32'h06, v & 32'hff);
		i_host_model.wr(4'h0, 32'h85);
		idle();
		i_host_model.rd(4'h4, v);
		chk("data_read", 32'h41, v & 32'hff);
		idle();
		$display("test done: address and data");
		i_host_model.wr(4'h0, 32'h05);
		idle();
		i_host_model.wr(4'h0, 32'h01);
		i_host_model.rd(4'h0, v);
		chk("busy_bit", 32'h1, {31'h0, v[7]});
		chk("busy_pin", 32'h1, {31'h0, busy});
		i_host_model.wr(4'h4, 32'h55);
		i_host_model.rd(4'h8, v);
		chk("rejected", 32'h1, {31'h0, v[16]});
		idle();
		chk("clear_addr", 32'h00, v & 32'hff);
		i_host_model.rd(4'h8, v);
		chk("clear_mode", 32'h0001_0030, v & 32'h7f01_0030);
		i_host_model.rd(4'h4, v);
		chk("blank", 32'h20, v & 32'hff);
		idle();
		i_host_model.wr(4'h8, 32'h0001_0000);
		i_host_model.rd(4'h8, v);
		chk("reject_clr", 32'h0, {31'h0, v[16]});
		$display("test done: clear and refusal");
		i_host_model.wr(4'h0, 32'h0c);
		idle();
		chk("display_on", 32'h1, {31'h0, don});
		i_host_model.wr(4'h0, 32'h1f);
		idle();
		chk("mode_pwr", 32'h3, {30'h0, gm, dc});
		i_host_model.wr(4'h0, 32'h43);
		idle();
		chk("glyph_addr", 32'h03, v & 32'hff);
		i_host_model.rd(4'h8, v);
		chk("glyph_sel", 32'h8, v & 32'h8);
		i_host_model.wr(4'h4, 32'ha5);
		idle();
		i_host_model.wr(4'h0, 32'h43);
		idle();
		i_host_model.rd(4'h4, v);
		chk("glyph_data", 32'ha5, v & 32'hff);
		idle();
		i_host_model.wr(4'h0, 32'h10);
		idle();
		chk("cursor_left", 32'h03, v & 32'hff);
		i_host_model.rd(4'h8, v);
		chk("shift_count", 32'h0300_0000, v & 32'h7f00_0000);
		i_host_model.wr(4'h0, 32'h02);
		idle();
		chk("home_addr", 32'h00, v & 32'hff);
		i_host_model.rd(4'h8, v);
		chk("home_shift", 32'h0, v & 32'h7f00_0008);
		i_host_model.rd(4'hc, v);
		chk("unmapped", 32'h0, v);
		$display("test done: modes and glyph RAM");
		i_host_model.wr(4'h0, 32'h2b);
		four_bit = 1'b1;
		idle();
		i_host_model.rd(4'h8, v);
		chk("func_set", 32'h0000_1000, v & 32'h0000_f800);
		i_host_model.wr(4'h0, 32'h80);
		i_host_model.wr(4'h0, 32'h70);
		idle();
		chk("nibble_addr", 32'h07, v & 32'hff);
		i_host_model.wr(4'h4, 32'h30);
		i_host_model.wr(4'h4, 32'hc0);
		idle();
		chk("nibble_step", 32'h08, v & 32'hff);
		i_host_model.wr(4'h0, 32'h80);
		i_host_model.wr(4'h0, 32'h70);
		idle();
		i_host_model.rd(4'h4, v);
		i_host_model.rd(4'h4, v2);
		chk("nibble_data", 32'h3c, {24'h0, v[7:4], v2[7:4]});
		idle();
		$display("test done: nibble transfers");
		report_and_stop();
	end
endmodule

// ===== char_ram.sv
`timescale 1ns/1ps
// Purpose: Display RAM and glyph RAM storage.
// Assumes: One access per cycle, chosen by the decoder.
// Notes: Contents are not reset; a clear instruction blanks display RAM.
module char_ram #(
	parameter int DISP_DEPTH = char_disp_pkg::DISP_DEPTH,
	parameter int GLYPH_DEPTH = char_disp_pkg::GLYPH_DEPTH
) (
	input wire logic clk_i,
	ram_port_if.store port
);
	localparam int DW = $clog2(DISP_DEPTH);
	localparam int GW = $clog2(GLYPH_DEPTH);

	logic [7:0] disp_mem [DISP_DEPTH];
	logic [7:0] glyph_mem [GLYPH_DEPTH];

	always_ff @(posedge clk_i) begin
		if (port.we) begin
			if (port.glyph) glyph_mem[port.addr[GW-1:0]] <= port.wdata;
			else disp_mem[port.addr[DW-1:0]] <= port.wdata;
		end
	end

	assign port.rdata = port.glyph ? glyph_mem[port.addr[GW-1:0]] : disp_mem[port.addr[DW-1:0]];
endmodule

// ===== host_model.sv
// Purpose: Host side model, a classic Wishbone master with single-cycle accesses.
// Assumes: Slave answers with ack; the wait for ack is bounded.
// Notes: Raises hang_o when an answer never comes.
`timescale 1ns/1ps
module host_model (
	input wire logic clk_i,
	input wire logic ack_i,
	input wire logic [31:0] dat_i,
	output logic cyc_o,
	output logic stb_o,
	output logic we_o,
	output logic [3:0] adr_o,
	output logic [3:0] sel_o,
	output logic [31:0] dat_o,
	output logic hang_o
);
	initial begin
		{cyc_o, stb_o, we_o, hang_o} = 4'h0;
		adr_o = 4'h0;
		sel_o = 4'h0;
		dat_o = 32'h0;
	end
	// Ack and read data are looked at before the edge's updates land
	task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
			output logic [31:0] q);
		int n;
		@(posedge clk_i);
		{cyc_o, stb_o, we_o} <= {1'b1, 1'b1, w};
		adr_o <= a;
		sel_o <= 4'hf;
		dat_o <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_i !== 1'b1 && n < 20);
		if (ack_i !== 1'b1) hang_o <= 1'b1;
		q = dat_i;
		{cyc_o, stb_o, we_o} <= 3'h0;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] q);
		xfer(1'b0, a, 32'h0, q);
	endtask
endmodule

// ===== ram_port_if.sv
`timescale 1ns/1ps
// Purpose: Port between the decoder and its character RAM store.
// Assumes: Write is synchronous, read is combinational.
// Notes: glyph selects the glyph RAM, else display RAM.
interface ram_port_if;
	logic we;
	logic glyph;
	logic [char_disp_pkg::ADDR_W-1:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport ctrl (output we, output glyph, output addr, output wdata, input rdata);
	modport store (input we, input glyph, input addr, input wdata, output rdata);
endinterface
